// file: sio_pkg.sv
`default_nettype none
// ==========================================================================
// Shared interrupt pin multiplexer constants
package sio_pkg;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] SIO_IDX_CALIB = 8'h08;
  localparam logic [7:0] SIO_IDX_WDOG = 8'h09;
  localparam logic [7:0] SIO_IDX_A1MON = 8'h0A;
  localparam logic [7:0] SIO_IDX_FLAGS = 8'h0F;
  localparam logic [7:0] SIO_IDX_TCTL = 8'h11;
  localparam logic [7:0] SIO_IDX_PINST = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int SIO_BIT_OUT = 7;
  localparam int SIO_BIT_FT = 6;
  localparam int SIO_BIT_OSC_FAIL_IRQ_ENABLE = 7;
  localparam int SIO_BIT_ALARM_ONE_IRQ_ENABLE = 7;
  localparam int SIO_BIT_ABE = 5;
  localparam int SIO_BIT_TIE = 5;
  localparam int SIO_BIT_FLG_WD = 7;
  localparam int SIO_BIT_FLG_A1 = 6;
  localparam int SIO_BIT_FLG_TI = 3;
  localparam int SIO_BIT_FLG_OF = 2;
  localparam int SIO_BIT_ST_LOW = 0;
  localparam int SIO_BIT_ST_BKUP = 1;
  localparam int SIO_BIT_ST_SQ = 2;
  localparam int SIO_BIT_ST_PIN = 3;
  localparam int SIO_BIT_ST_MODE = 4;

  // ==========================================================================
  // Reset values
  localparam logic SIO_RST_OUT = 1'b1;
  localparam logic SIO_RST_FT = 1'b0;
  localparam logic SIO_RST_OSC_FAIL_IRQ_ENABLE = 1'b0;
  localparam logic SIO_RST_ALARM_ONE_IRQ_ENABLE = 1'b0;
  localparam logic SIO_RST_ABE = 1'b0;
  localparam logic SIO_RST_TIE = 1'b0;
  localparam logic SIO_RST_OF = 1'b1;

  // ==========================================================================
  // Synchronised input vector layout
  localparam int SIO_NSYNC = 8;
  localparam int SIO_IN_BKUP = 0;
  localparam int SIO_IN_SQ = 1;
  localparam int SIO_IN_TREQ = 2;
  localparam int SIO_IN_A1REQ = 3;
  localparam int SIO_IN_WREQ = 4;
  localparam int SIO_IN_WRUN = 5;
  localparam int SIO_IN_OSTOP = 6;
  localparam int SIO_IN_PIN = 7;

  // Test square wave rate
  localparam int SIO_SQ_HZ = 512;

  // ==========================================================================
  // Pin source selection
  typedef enum logic [1:0] {
    SIO_MODE_LOW,
    SIO_MODE_SQ,
    SIO_MODE_IRQ,
    SIO_MODE_HIGH
  } sio_mode_t;

endpackage : sio_pkg
`default_nettype wire

// file: sio_irq_mux.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
// Functional notes
// - Timer, oscillator-fail, alarm-one and watchdog requests are ORed into one interrupt.
// - Pin is open drain: only pulls low or releases, never drives high.
// - Test enable with its path selected puts the 512 Hz square wave on the pin.
// - Main supply, level bit 0, test enable 0: pin held low.
// - Main supply, test enable 1: square wave when level bit 0 or nothing enabled.
// - Main supply, level bit 1, some enable: pin high until enabled interrupt asserts.
// - Main supply, level 1, test 0, nothing enabled: pin released high.
// - Backup: timer and watchdog ignored, only alarm-one and oscillator-fail count.
// - Backup with allow bit 0: pin released high whatever else.
// - Backup: test enable has no effect on the pin.
// - Backup, level 1, neither alarm-one nor oscillator-fail enabled: pin high.
// - Backup, allow 1, level 0: pin held low.
// - Backup: pin follows interrupt only with allow, level and an enable all 1.
// - Level bit is bit 7 of calibration register 08h.
// - Test enable is bit 6 of calibration register 08h.
// - Alarm-one enable bit 7 and backup allow bit 5 of register 0Ah.
// - Oscillator-fail enable is bit 7 of register 09h.
// - Timer enable is bit 5 of register 11h.
// - Further sources while pin already low cause no extra transition.
// - Oscillator-fail flag stays set until written 0; reading does not clear.
// - Clearing oscillator-fail enable releases; setting it again with flag set reasserts.
module sio_irq_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic backup_mode,
  input wire logic freq_512,
  input wire logic timer_req,
  input wire logic alarm_one_req,
  input wire logic watchdog_req,
  input wire logic watchdog_running,
  input wire logic osc_stopped,
  input wire logic shared_irq_pin_i,
  output logic shared_irq_pin_o,
  output logic shared_irq_pin_oe_n
);
  import sio_pkg::*;

  // ==========================================================================
  // Address helper
  function automatic logic [7:0] sio_byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : sio_byte_addr

  // ==========================================================================
  // Declarations
  logic [SIO_NSYNC-1:0] sync1;
  logic [SIO_NSYNC-1:0] sync2;
  logic [SIO_NSYNC-1:0] sync3;
  logic [SIO_NSYNC-1:0] in_s;
  logic out_lvl;
  logic freq_test_enable;
  logic osc_fail_irq_enable;
  logic alarm_one_irq_enable;
  logic backup_irq_allow;
  logic timer_irq_enable;
  logic osc_fail_flag;
  sio_mode_t pin_mode;
  sio_mode_t next_mode;
  logic next_low;
  logic any_en_main;
  logic any_en_bkup;
  logic irq_main;
  logic irq_bkup;
  logic bkup_s;
  logic sq_s;
  logic setup_ph;
  logic wr_en;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] pin_status;

  assign bkup_s = in_s[SIO_IN_BKUP];
  assign sq_s = in_s[SIO_IN_SQ];
  assign wbyte = pwdata[7:0];
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // ==========================================================================
  // Input synchronisers, change taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {shared_irq_pin_i, osc_stopped, watchdog_running, watchdog_req,
                alarm_one_req, timer_req, freq_512, backup_mode};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s <= '0;
    end else begin
      for (int i = 0; i < SIO_NSYNC; i++) begin
        if (sync2[i] == sync3[i]) begin
          in_s[i] <= sync3[i];
        end
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lvl <= SIO_RST_OUT;
      freq_test_enable <= SIO_RST_FT;
    end else if (wr_en && paddr == sio_byte_addr(SIO_IDX_CALIB)) begin
      out_lvl <= wbyte[SIO_BIT_OUT];
      freq_test_enable <= wbyte[SIO_BIT_FT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_fail_irq_enable <= SIO_RST_OSC_FAIL_IRQ_ENABLE;
    end else if (wr_en && paddr == sio_byte_addr(SIO_IDX_WDOG)) begin
      osc_fail_irq_enable <= wbyte[SIO_BIT_OSC_FAIL_IRQ_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_one_irq_enable <= SIO_RST_ALARM_ONE_IRQ_ENABLE;
      backup_irq_allow <= SIO_RST_ABE;
    end else if (wr_en && paddr == sio_byte_addr(SIO_IDX_A1MON)) begin
      alarm_one_irq_enable <= wbyte[SIO_BIT_ALARM_ONE_IRQ_ENABLE];
      backup_irq_allow <= wbyte[SIO_BIT_ABE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_enable <= SIO_RST_TIE;
    end else if (wr_en && paddr == sio_byte_addr(SIO_IDX_TCTL)) begin
      timer_irq_enable <= wbyte[SIO_BIT_TIE];
    end
  end

  // ==========================================================================
  // Oscillator-fail flag, set wins over a write of 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_fail_flag <= SIO_RST_OF;
    end else if (in_s[SIO_IN_OSTOP]) begin
      osc_fail_flag <= 1'b1;
    end else if (wr_en && paddr == sio_byte_addr(SIO_IDX_FLAGS) && !wbyte[SIO_BIT_FLG_OF]) begin
      osc_fail_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt conditions
  always_comb begin
    any_en_main = alarm_one_irq_enable || osc_fail_irq_enable || timer_irq_enable
                  || in_s[SIO_IN_WRUN];
    irq_main = (in_s[SIO_IN_TREQ] && timer_irq_enable)
               || (osc_fail_flag && osc_fail_irq_enable)
               || (in_s[SIO_IN_A1REQ] && alarm_one_irq_enable)
               || (in_s[SIO_IN_WREQ] && in_s[SIO_IN_WRUN]);
    any_en_bkup = alarm_one_irq_enable || osc_fail_irq_enable;
    irq_bkup = (osc_fail_flag && osc_fail_irq_enable)
               || (in_s[SIO_IN_A1REQ] && alarm_one_irq_enable);
  end

  // ==========================================================================
  // Priority selection
  always_comb begin
    next_mode = SIO_MODE_HIGH;
    if (!bkup_s) begin
      if (!out_lvl && !freq_test_enable) begin
        next_mode = SIO_MODE_LOW;
      end else if (freq_test_enable && (!out_lvl || !any_en_main)) begin
        next_mode = SIO_MODE_SQ;
      end else if (any_en_main) begin
        next_mode = SIO_MODE_IRQ;
      end else begin
        next_mode = SIO_MODE_HIGH;
      end
    end else begin
      if (!backup_irq_allow) begin
        next_mode = SIO_MODE_HIGH;
      end else if (!out_lvl) begin
        next_mode = SIO_MODE_LOW;
      end else if (!any_en_bkup) begin
        next_mode = SIO_MODE_HIGH;
      end else begin
        next_mode = SIO_MODE_IRQ;
      end
    end
  end

  always_comb begin
    next_low = 1'b0;
    unique case (next_mode)
      SIO_MODE_LOW: next_low = 1'b1;
      SIO_MODE_SQ: next_low = !sq_s;
      SIO_MODE_IRQ: next_low = bkup_s ? irq_bkup : irq_main;
      SIO_MODE_HIGH: next_low = 1'b0;
    endcase
  end

  // ==========================================================================
  // Pin drive, open drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode <= SIO_MODE_HIGH;
      shared_irq_pin_oe_n <= 1'b1;
      shared_irq_pin_o <= 1'b0;
    end else begin
      pin_mode <= next_mode;
      shared_irq_pin_oe_n <= !next_low;
      shared_irq_pin_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Read decode
  assign pin_status = {2'b00, pin_mode, in_s[SIO_IN_PIN], sq_s, bkup_s, !shared_irq_pin_oe_n};

  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    if (paddr == sio_byte_addr(SIO_IDX_CALIB)) begin
      rd_byte[SIO_BIT_OUT] = out_lvl;
      rd_byte[SIO_BIT_FT] = freq_test_enable;
    end else if (paddr == sio_byte_addr(SIO_IDX_WDOG)) begin
      rd_byte[SIO_BIT_OSC_FAIL_IRQ_ENABLE] = osc_fail_irq_enable;
    end else if (paddr == sio_byte_addr(SIO_IDX_A1MON)) begin
      rd_byte[SIO_BIT_ALARM_ONE_IRQ_ENABLE] = alarm_one_irq_enable;
      rd_byte[SIO_BIT_ABE] = backup_irq_allow;
    end else if (paddr == sio_byte_addr(SIO_IDX_TCTL)) begin
      rd_byte[SIO_BIT_TIE] = timer_irq_enable;
    end else if (paddr == sio_byte_addr(SIO_IDX_FLAGS)) begin
      rd_byte[SIO_BIT_FLG_WD] = in_s[SIO_IN_WREQ];
      rd_byte[SIO_BIT_FLG_A1] = in_s[SIO_IN_A1REQ];
      rd_byte[SIO_BIT_FLG_TI] = in_s[SIO_IN_TREQ];
      rd_byte[SIO_BIT_FLG_OF] = osc_fail_flag;
    end else if (paddr == sio_byte_addr(SIO_IDX_PINST)) begin
      rd_byte = pin_status;
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================================================
  // APB answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit;
      if (setup_ph && !pwrite && hit) begin
        prdata <= 32'(rd_byte);
      end else if (setup_ph) begin
        prdata <= '0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_main_low;
    !bkup_s && !out_lvl && !freq_test_enable;
  endsequence

  sequence s_calib_wr(logic [7:0] b);
    wr_en && paddr == sio_byte_addr(SIO_IDX_CALIB) && wbyte == b;
  endsequence

  sequence s_of_armed;
    osc_fail_flag && osc_fail_irq_enable && !bkup_s && out_lvl;
  endsequence

  sequence s_bkup_follow;
    bkup_s && backup_irq_allow && out_lvl && (alarm_one_irq_enable || osc_fail_irq_enable);
  endsequence

  chk_main_held_low: assert property (s_main_low |=> !shared_irq_pin_oe_n)
    else $error("pin not low with level and test bits clear");

  chk_main_square: assert property (!bkup_s && freq_test_enable && !out_lvl
      |=> shared_irq_pin_oe_n == $past(sq_s))
    else $error("square wave not on pin");

  chk_main_release: assert property (!bkup_s && out_lvl && !freq_test_enable && !any_en_main
      |=> shared_irq_pin_oe_n)
    else $error("pin not released with nothing enabled");

  chk_main_irq_or: assert property (!bkup_s && out_lvl && in_s[SIO_IN_WRUN] && in_s[SIO_IN_WREQ]
      |=> !shared_irq_pin_oe_n)
    else $error("watchdog request did not pull pin low");

  chk_bkup_no_allow: assert property (bkup_s && !backup_irq_allow |=> shared_irq_pin_oe_n)
    else $error("pin pulled low in backup without allow");

  chk_bkup_level_low: assert property (bkup_s && backup_irq_allow && !out_lvl
      |=> !shared_irq_pin_oe_n)
    else $error("pin not low in backup with level 0");

  chk_bkup_timer_ignored: assert property (bkup_s && !alarm_one_irq_enable && !osc_fail_irq_enable
      && out_lvl |=> shared_irq_pin_oe_n)
    else $error("timer or watchdog affected pin in backup");

  chk_bkup_timer_masked: assert property (s_bkup_follow ##0 (!in_s[SIO_IN_A1REQ] && !osc_fail_flag)
      |=> shared_irq_pin_oe_n)
    else $error("timer or watchdog request pulled pin in backup");

  chk_bkup_alarm_irq: assert property (s_bkup_follow ##0 (alarm_one_irq_enable && in_s[SIO_IN_A1REQ])
      |=> !shared_irq_pin_oe_n)
    else $error("alarm-one request did not pull pin in backup");

  chk_bkup_ft_ignored: assert property (bkup_s && backup_irq_allow && out_lvl && freq_test_enable
      && !alarm_one_irq_enable && !osc_fail_irq_enable |=> shared_irq_pin_oe_n)
    else $error("test enable affected pin in backup");

  chk_never_drive_high: assert property (shared_irq_pin_o == 1'b0)
    else $error("pin data not low");

  chk_of_sticky: assert property (osc_fail_flag && !(wr_en && paddr == sio_byte_addr(SIO_IDX_FLAGS))
      |=> osc_fail_flag)
    else $error("oscillator-fail flag cleared without write");

  chk_of_reassert: assert property (!osc_fail_irq_enable ##1 s_of_armed |=> !shared_irq_pin_oe_n)
    else $error("oscillator-fail enable did not reassert pin");

  chk_of_release: assert property (!bkup_s && out_lvl && !freq_test_enable && $fell(osc_fail_irq_enable)
      && !in_s[SIO_IN_TREQ] && !in_s[SIO_IN_A1REQ] && !in_s[SIO_IN_WREQ] |=> shared_irq_pin_oe_n)
    else $error("clearing oscillator-fail enable did not release pin");

  chk_calib_write: assert property (s_calib_wr(8'h40) |=> !out_lvl && freq_test_enable)
    else $error("calibration write did not land in level and test bits");

  chk_wdog_write: assert property (wr_en && paddr == sio_byte_addr(SIO_IDX_WDOG)
      |=> osc_fail_irq_enable == $past(wbyte[SIO_BIT_OSC_FAIL_IRQ_ENABLE]))
    else $error("watchdog register write did not land in enable");

  chk_tctl_write: assert property (wr_en && paddr == sio_byte_addr(SIO_IDX_TCTL)
      |=> timer_irq_enable == $past(wbyte[SIO_BIT_TIE]))
    else $error("timer control write did not land in enable");

  chk_a1mon_write: assert property (wr_en && paddr == sio_byte_addr(SIO_IDX_A1MON)
      |=> alarm_one_irq_enable == $past(wbyte[SIO_BIT_ALARM_ONE_IRQ_ENABLE])
      && backup_irq_allow == $past(wbyte[SIO_BIT_ABE]))
    else $error("alarm-one month write did not land in enable and allow");

  chk_low_holds: assert property (!bkup_s && !shared_irq_pin_oe_n && pin_mode == SIO_MODE_IRQ
      && next_mode == SIO_MODE_IRQ && alarm_one_irq_enable && $rose(in_s[SIO_IN_A1REQ]) |=> !shared_irq_pin_oe_n)
    else $error("extra transition while already low");

endmodule : sio_irq_mux
`default_nettype wire

// file: sio_host_model.sv
`default_nettype none
// ====================
// Host interrupt input with external pull-up
module sio_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shared_irq_pin_o,
  input wire logic shared_irq_pin_oe_n,
  output logic pin_level,
  output logic [7:0] fall_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_level;

  // ====================
  // Wire level, pull-up when released
  assign pin_level = shared_irq_pin_oe_n ? 1'b1 : shared_irq_pin_o;

  // ====================
  // Falling edges seen by the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_level <= 1'b1;
      fall_count <= 8'h00;
    end else begin
      last_level <= pin_level;
      if (last_level && !pin_level) begin
        fall_count <= fall_count + 8'h01;
      end
    end
  end
endmodule : sio_host_model
`default_nettype wire

// file: testbench.sv
`default_nettype none
// ====================
// Shared interrupt pin testbench
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sio_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin_o, pin_oe_n, pin_level;
  logic backup_mode = 1'b0, freq_512 = 1'b0, timer_req = 1'b0, alarm_one_req = 1'b0;
  logic watchdog_req = 1'b0, watchdog_running = 1'b0, osc_stopped = 1'b0;
  logic [7:0] falls;
  int miscompares = 0;
  int comparisons = 0;

  always #12.5 pclk = ~pclk;

  sio_irq_mux sio_irq_mux_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .backup_mode(backup_mode), .freq_512(freq_512), .timer_req(timer_req),
    .alarm_one_req(alarm_one_req), .watchdog_req(watchdog_req),
    .watchdog_running(watchdog_running), .osc_stopped(osc_stopped),
    .shared_irq_pin_i(pin_level), .shared_irq_pin_o(pin_o), .shared_irq_pin_oe_n(pin_oe_n)
  );

  sio_host_model sio_host_model_i (
    .pclk(pclk), .presetn(presetn), .shared_irq_pin_o(pin_o),
    .shared_irq_pin_oe_n(pin_oe_n), .pin_level(pin_level), .fall_count(falls)
  );

  // ====================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic settle();
    repeat (7) @(posedge pclk);
  endtask : settle

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    check("access cycles", 32'h1, 32'(n));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00, rd, err);
    check("read data", exp, rd);
  endtask : rdchk

  task automatic pin_is(input logic exp);
    settle();
    check("pin level", {31'h0, exp}, {31'h0, pin_level});
    check("pin driven high", 32'h0, {31'h0, pin_o & ~pin_oe_n});
  endtask : pin_is

  // Kind 0 low, 1 square wave, 2 high
  task automatic expect_pin(input int kind);
    freq_512 <= 1'b1;
    pin_is(kind != 0);
    freq_512 <= 1'b0;
    pin_is(kind == 2);
  endtask : expect_pin

  // ====================
  // Scenarios
  task automatic reset_values();
    rdchk(8'h20, 32'h80);
    rdchk(8'h24, 32'h00);
    rdchk(8'h28, 32'h00);
    rdchk(8'h44, 32'h00);
    rdchk(8'h3C, 32'h04);
    apb(1'b0, 8'h04, 8'h00, rd, err);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    expect_pin(2);
    rdchk(8'h80, 32'h38);
  endtask : reset_values

  task automatic main_table();
    logic [2:0] cfg [5] = '{3'b001, 3'b011, 3'b110, 3'b111, 3'b100};
    int kind [5] = '{0, 1, 1, 2, 2};
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, {cfg[i][2], cfg[i][1], 6'h00});
      wr(8'h44, {2'b00, cfg[i][0], 5'h00});
      expect_pin(kind[i]);
    end
  endtask : main_table

  task automatic sources();
    int f;
    wr(8'h20, 8'h80);
    wr(8'h44, 8'h20);
    wr(8'h28, 8'h80);
    watchdog_running <= 1'b1;
    pin_is(1'b1);
    f = falls;
    timer_req <= 1'b1;
    pin_is(1'b0);
    alarm_one_req <= 1'b1;
    pin_is(1'b0);
    check("fall count", 32'(f + 1), {24'h0, falls});
    timer_req <= 1'b0;
    pin_is(1'b0);
    alarm_one_req <= 1'b0;
    watchdog_req <= 1'b1;
    pin_is(1'b0);
    watchdog_req <= 1'b0;
    pin_is(1'b1);
    wr(8'h24, 8'h80);
    pin_is(1'b0);
    rdchk(8'h3C, 32'h04);
    pin_is(1'b0);
    wr(8'h24, 8'h00);
    pin_is(1'b1);
    wr(8'h24, 8'h80);
    pin_is(1'b0);
    wr(8'h3C, 8'h00);
    pin_is(1'b1);
    rdchk(8'h3C, 32'h00);
    osc_stopped <= 1'b1;
    settle();
    wr(8'h3C, 8'h00);
    rdchk(8'h3C, 32'h04);
    osc_stopped <= 1'b0;
    settle();
    wr(8'h3C, 8'h00);
    rdchk(8'h3C, 32'h00);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h00);
  endtask : sources

  task automatic backup();
    backup_mode <= 1'b1;
    wr(8'h20, 8'h00);
    pin_is(1'b1);
    wr(8'h28, 8'h20);
    pin_is(1'b0);
    wr(8'h20, 8'hC0);
    timer_req <= 1'b1;
    watchdog_req <= 1'b1;
    expect_pin(2);
    wr(8'h28, 8'hA0);
    pin_is(1'b1);
    alarm_one_req <= 1'b1;
    pin_is(1'b0);
    settle();
    rdchk(8'h80, 32'h23);
    wr(8'h28, 8'h80);
    pin_is(1'b1);
    backup_mode <= 1'b0;
    pin_is(1'b0);
    timer_req <= 1'b0;
    watchdog_req <= 1'b0;
    alarm_one_req <= 1'b0;
  endtask : backup

  // ====================
  // Verdict
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    main_table();
    sources();
    backup();
    conclude();
  end
endmodule : testbench
`default_nettype wire
